/* File: inc/pbf_pkg.sv */
/*
 * Shared constants and types for the pixel burst acquisition block and its ping-pong burst buffer.
 * Assumes a single system clock; transfer clock edges arrive as a level input sampled on that clock.
 */
package pbf_pkg;

	// ************************************************************
	// Widths and sizes
	// ************************************************************
	localparam int PIX_W      = 18;
	localparam int ADDR_W     = 25;
	localparam int BURST_DEF  = 4;
	localparam int BANK_DEPTH = 8;
	localparam int REG_AW     = 8;
	localparam int CNT_W      = 16;
	localparam int NCH_W      = 4;

	// ************************************************************
	// Register offsets (byte addresses)
	// ************************************************************
	localparam logic [REG_AW-1:0] OFS_CTRL   = 8'h00;
	localparam logic [REG_AW-1:0] OFS_BASE   = 8'h04;
	localparam logic [REG_AW-1:0] OFS_CSTEP  = 8'h08;
	localparam logic [REG_AW-1:0] OFS_RSTEP  = 8'h0c;
	localparam logic [REG_AW-1:0] OFS_NCOL   = 8'h10;
	localparam logic [REG_AW-1:0] OFS_NROW   = 8'h14;
	localparam logic [REG_AW-1:0] OFS_STATUS = 8'h18;
	localparam logic [REG_AW-1:0] OFS_ADDR   = 8'h1c;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int CTRL_STREAM_BIT = 0;
	localparam int CTRL_LIFO_BIT   = 1;
	localparam int CTRL_SRST_BIT   = 2;
	localparam int CTRL_NCH_LSB    = 3;
	localparam int STAT_REQ_BIT    = 0;
	localparam int STAT_FULL_BIT   = 1;
	localparam int STAT_BUSY_BIT   = 2;
	localparam int STAT_ARMED_BIT  = 3;

	localparam logic              STREAM_RST = 1'b1;
	localparam logic              LIFO_RST   = 1'b0;
	localparam logic [NCH_W-1:0]  NCH_RST    = 4'h1;
	localparam logic [ADDR_W-1:0] BASE_RST   = 25'h0000000;
	localparam logic [ADDR_W-1:0] CSTEP_RST  = 25'h0000001;
	localparam logic [ADDR_W-1:0] RSTEP_RST  = 25'h0000001;
	localparam logic [CNT_W-1:0]  NCOL_RST   = 16'h0004;
	localparam logic [CNT_W-1:0]  NROW_RST   = 16'h0001;
	localparam logic [1:0]        BURST_CNT_LAST = 2'h3;

	// ************************************************************
	// State machine types
	// ************************************************************
	typedef enum logic [1:0] {WM_IDLE, WM_ACTIVE, WM_HOLD} pbf_wmon_t;
	typedef enum logic [1:0] {AG_IDLE, AG_CONFIG, AG_STREAM, AG_CONTIG} pbf_agen_t;
	typedef enum logic {BS_IDLE, BS_PEND} pbf_bstat_t;
	typedef enum logic [2:0] {RD_INIT, RD_PING_FIFO, RD_PING_LIFO, RD_PONG_FIFO, RD_PONG_LIFO} pbf_brd_t;

endpackage : pbf_pkg

/* File: hw/pbf_burst_buf.sv */
/*
 * Ping-pong burst buffer: two banks of 18-bit words, one filled while the other is drained.
 * Assumes fall_en and rise_en are one-cycle pulses marking the transfer clock edges.
 */
`timescale 1ns/1ps
module pbf_burst_buf #(
	parameter int BURST = pbf_pkg::BURST_DEF,
	parameter int DEPTH = pbf_pkg::BANK_DEPTH,
	parameter int W     = pbf_pkg::PIX_W
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic         srst,
	input  wire logic         rise_en,
	input  wire logic         fall_en,
	input  wire logic         wr_strobe,
	input  wire logic [W-1:0] wr_data,
	input  wire logic         rd_strobe,
	input  wire logic         order_lifo,
	output logic      [W-1:0] rd_data,
	output logic      [1:0]   bank_full
);
	import pbf_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(BURST - 1);

	logic [W-1:0]  mem_reg [0:2*DEPTH-1];
	logic [PW-1:0] wptr_reg;
	logic          wbank_reg;
	logic [PW-1:0] rptr_reg;
	logic [PW-1:0] rcnt_reg;
	logic [1:0]    pend_reg;
	logic [1:0]    take;
	pbf_brd_t      rstate_reg;
	logic          rbank;
	logic          rlifo;
	logic [PW-1:0] rptr_next;

	// ************************************************************
	// Write side
	// ************************************************************
	// Sampling on the falling edge gives the data half a transfer cycle to settle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wptr_reg  <= '0;
			wbank_reg <= 1'b0;
			bank_full <= 2'b00;
		end else if (srst) begin
			wptr_reg  <= '0;
			wbank_reg <= 1'b0;
			bank_full <= 2'b00;
		end else begin
			bank_full <= 2'b00;
			if (fall_en && wr_strobe) begin
				if (wptr_reg == LAST) begin
					wptr_reg             <= '0;
					bank_full[wbank_reg] <= 1'b1;
					wbank_reg            <= ~wbank_reg;
				end else begin
					wptr_reg <= wptr_reg + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (fall_en && wr_strobe) begin
			mem_reg[{wbank_reg, wptr_reg}] <= wr_data;
		end
	end

	// ************************************************************
	// Read side
	// ************************************************************
	assign rbank     = (rstate_reg == RD_PONG_FIFO) || (rstate_reg == RD_PONG_LIFO);
	assign rlifo     = (rstate_reg == RD_PING_LIFO) || (rstate_reg == RD_PONG_LIFO);
	assign rptr_next = rlifo ? rptr_reg - 1'b1 : rptr_reg + 1'b1;

	always_comb begin
		take = 2'b00;
		if (rise_en && rstate_reg == RD_INIT) begin
			if (pend_reg[0]) begin
				take = 2'b01;
			end else if (pend_reg[1]) begin
				take = 2'b10;
			end
		end
	end

	// A fill pulse landing in the cycle its older copy is taken still counts.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= 2'b00;
		end else if (srst) begin
			pend_reg <= 2'b00;
		end else begin
			pend_reg <= (pend_reg & ~take) | bank_full;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstate_reg <= RD_INIT;
			rptr_reg   <= '0;
			rcnt_reg   <= '0;
			rd_data    <= '0;
		end else if (srst) begin
			rstate_reg <= RD_INIT;
			rptr_reg   <= '0;
			rcnt_reg   <= '0;
		end else if (rise_en) begin
			case (rstate_reg)
				RD_INIT: begin
					if (take != 2'b00) begin
						rcnt_reg   <= '0;
						rptr_reg   <= order_lifo ? LAST : '0;
						rd_data    <= mem_reg[{take[1], (order_lifo ? LAST : {PW{1'b0}})}];
						if (take[1]) begin
							rstate_reg <= order_lifo ? RD_PONG_LIFO : RD_PONG_FIFO;
						end else begin
							rstate_reg <= order_lifo ? RD_PING_LIFO : RD_PING_FIFO;
						end
					end
				end
				RD_PING_FIFO, RD_PING_LIFO, RD_PONG_FIFO, RD_PONG_LIFO: begin
					if (rd_strobe) begin
						// The last acknowledge leaves the final word standing; the slot past it was never written.
						if (rcnt_reg == LAST) begin
							rstate_reg <= RD_INIT;
						end else begin
							rd_data  <= mem_reg[{rbank, rptr_next}];
							rcnt_reg <= rcnt_reg + 1'b1;
							rptr_reg <= rptr_next;
						end
					end
				end
				default: begin
					rstate_reg <= RD_INIT;
				end
			endcase
		end
	end

endmodule : pbf_burst_buf

/* File: hw/pbf_acq_top.sv */
/*
 * Acquisition control for one video channel: burst-write monitor, buffer address generator,
 * burst status handshake and the ping-pong burst buffer, with a small register port.
 * Assumes all inputs except rstn, including the inverted transfer clock level, are synchronous to clk_sys.
 */
// How it works
// - Word strobes are counted on falling transfer-clock edges.
// - Writer waits for exposure start, then flags full after four strobes.
// - The full flag stays set one more transfer cycle, then writer idles.
// - Address generator steps on rising transfer-clock edges.
// - Exposure start enters configuration: load base and order select, clear column and row.
// - Configuration leads to stream or contiguous addressing by stream mode.
// - Each accepted acknowledge advances the buffer address.
// - Stream mode steps the address by the active channel count.
// - Contiguous mode steps by column and row steps; bases spaced by software.
// - After the last pixel, generator idles and pulses frame complete.
// - Status machine raises request on full, drops it after four acknowledges.
// - Request rises on the first rising edge after the fourth strobe.
// - Acknowledges are counted per rising edge, pulse shape does not matter.
// - Word strobe drives buffer writes; acknowledge drives buffer reads.
// - Negative steps let a mirrored readout fill memory backwards.
// - Buffer holds two banks of eight words; fill bank swaps per burst.
// - Burst width is a parameter of one to four, four by default.
// - Buffer pulses a bank full flag when a burst is written.
// - Buffer reader waits for a full bank, then picks one of four states.
// - FIFO order reads ascending, LIFO order reads descending.
// - Read data is registered on rising edges with the read strobe.
// - Order select is zero for FIFO and one for LIFO.
// - Buffer writes sample the strobe on the falling edge.
`timescale 1ns/1ps
module pbf_acq_top #(
	parameter int BURST = pbf_pkg::BURST_DEF
) (
	input  wire logic                         clk_sys,
	input  wire logic                         rstn,
	input  wire logic                         inverted_transfer_clock,
	input  wire logic                         exposure_begin_pulse,
	input  wire logic                         converted_word_strobe,
	input  wire logic [pbf_pkg::PIX_W-1:0]    conv_data,
	input  wire logic                         read_ack_strobe,
	output logic                              burst_read_request,
	output logic      [pbf_pkg::PIX_W-1:0]    pixel_data,
	output logic      [pbf_pkg::ADDR_W-1:0]   buffer_addr,
	output logic                              order_select,
	input  wire logic [pbf_pkg::REG_AW-1:0]   reg_addr,
	input  wire logic [31:0]                  reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [31:0]                  reg_rdata
);
	import pbf_pkg::*;

	localparam logic [1:0] WCNT_LAST = 2'(BURST - 1);

	logic                    rst_meta_reg;
	logic                    rst_n;
	logic                    xclk_reg;
	logic                    rise_en;
	logic                    fall_en;
	logic                    srst;
	logic                    ack_ok;

	logic                    stream_reg;
	logic                    lifo_reg;
	logic [NCH_W-1:0]        nch_reg;
	logic [ADDR_W-1:0]       base_reg;
	logic [ADDR_W-1:0]       cstep_reg;
	logic [ADDR_W-1:0]       rstep_reg;
	logic [CNT_W-1:0]        ncol_reg;
	logic [CNT_W-1:0]        nrow_reg;

	pbf_wmon_t               wstate_reg;
	logic [1:0]              wcnt_reg;
	logic                    filled_reg;
	logic                    armed_reg;

	pbf_agen_t               astate_reg;
	logic                    start_pend_reg;
	logic                    frame_done;
	logic [CNT_W-1:0]        col_reg;
	logic [CNT_W-1:0]        row_reg;
	logic [ADDR_W-1:0]       sstep;
	logic                    last_col;
	logic                    last_row;

	pbf_bstat_t              bstate_reg;
	logic [1:0]              acnt_reg;

	// ************************************************************
	// Reset release and transfer clock edges
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// The transfer clock is slower than clk_sys, so its edges become one-cycle enables.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			xclk_reg <= 1'b0;
		end else begin
			xclk_reg <= inverted_transfer_clock;
		end
	end

	assign rise_en = inverted_transfer_clock && !xclk_reg;
	assign fall_en = !inverted_transfer_clock && xclk_reg;
	assign ack_ok  = read_ack_strobe && burst_read_request;

	// ************************************************************
	// Register port
	// ************************************************************
	assign srst = reg_wr && (reg_addr == OFS_CTRL) && reg_wdata[CTRL_SRST_BIT];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stream_reg <= STREAM_RST;
			lifo_reg   <= LIFO_RST;
			nch_reg    <= NCH_RST;
			base_reg   <= BASE_RST;
			cstep_reg  <= CSTEP_RST;
			rstep_reg  <= RSTEP_RST;
			ncol_reg   <= NCOL_RST;
			nrow_reg   <= NROW_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL: begin
					stream_reg <= reg_wdata[CTRL_STREAM_BIT];
					lifo_reg   <= reg_wdata[CTRL_LIFO_BIT];
					nch_reg    <= reg_wdata[CTRL_NCH_LSB +: NCH_W];
				end
				OFS_BASE:  base_reg  <= reg_wdata[ADDR_W-1:0];
				OFS_CSTEP: cstep_reg <= reg_wdata[ADDR_W-1:0];
				OFS_RSTEP: rstep_reg <= reg_wdata[ADDR_W-1:0];
				OFS_NCOL:  ncol_reg  <= reg_wdata[CNT_W-1:0];
				OFS_NROW:  nrow_reg  <= reg_wdata[CNT_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// Unmapped addresses and the write-only reset bit read back as zero.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				OFS_CTRL:   reg_rdata <= 32'({nch_reg, 1'b0, lifo_reg, stream_reg});
				OFS_BASE:   reg_rdata <= 32'(base_reg);
				OFS_CSTEP:  reg_rdata <= 32'(cstep_reg);
				OFS_RSTEP:  reg_rdata <= 32'(rstep_reg);
				OFS_NCOL:   reg_rdata <= 32'(ncol_reg);
				OFS_NROW:   reg_rdata <= 32'(nrow_reg);
				OFS_STATUS: reg_rdata <= 32'({armed_reg, (astate_reg != AG_IDLE), filled_reg, burst_read_request});
				OFS_ADDR:   reg_rdata <= 32'(buffer_addr);
				default:    reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// ************************************************************
	// Burst-write monitor
	// ************************************************************
	// The armed level keeps the monitor counting bursts until the frame completes;
	// an exposure start in the same cycle as frame completion wins.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			armed_reg <= 1'b0;
		end else if (srst) begin
			armed_reg <= 1'b0;
		end else if (exposure_begin_pulse) begin
			armed_reg <= 1'b1;
		end else if (frame_done) begin
			armed_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wstate_reg <= WM_IDLE;
			wcnt_reg   <= 2'h0;
			filled_reg <= 1'b0;
		end else if (srst) begin
			wstate_reg <= WM_IDLE;
			wcnt_reg   <= 2'h0;
			filled_reg <= 1'b0;
		end else if (fall_en) begin
			case (wstate_reg)
				WM_IDLE: begin
					wcnt_reg <= 2'h0;
					if (armed_reg || exposure_begin_pulse) begin
						wstate_reg <= WM_ACTIVE;
					end
				end
				WM_ACTIVE: begin
					if (converted_word_strobe) begin
						if (wcnt_reg == WCNT_LAST) begin
							filled_reg <= 1'b1;
							wstate_reg <= WM_HOLD;
						end else begin
							wcnt_reg <= wcnt_reg + 2'h1;
						end
					end
				end
				WM_HOLD: begin
					filled_reg <= 1'b0;
					wstate_reg <= WM_IDLE;
				end
				default: begin
					wstate_reg <= WM_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Address generator
	// ************************************************************
	// The exposure pulse is short and rarely meets a rising edge, so it is held until the next rising edge.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			start_pend_reg <= 1'b0;
		end else if (srst) begin
			start_pend_reg <= 1'b0;
		end else if (exposure_begin_pulse) begin
			start_pend_reg <= 1'b1;
		end else if (rise_en) begin
			start_pend_reg <= 1'b0;
		end
	end

	// Stream step is the channel count, negated for a mirrored readout.
	assign sstep    = lifo_reg ? ADDR_W'(0) - ADDR_W'(nch_reg) : ADDR_W'(nch_reg);
	assign last_col = (col_reg == ncol_reg - 16'h0001);
	assign last_row = (row_reg == nrow_reg - 16'h0001);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			astate_reg   <= AG_IDLE;
			buffer_addr  <= '0;
			order_select <= 1'b0;
			col_reg      <= '0;
			row_reg      <= '0;
			frame_done   <= 1'b0;
		end else if (srst) begin
			astate_reg   <= AG_IDLE;
			col_reg      <= '0;
			row_reg      <= '0;
			frame_done   <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			if (rise_en) begin
				case (astate_reg)
					AG_IDLE: begin
						if (start_pend_reg || exposure_begin_pulse) begin
							astate_reg <= AG_CONFIG;
						end
					end
					AG_CONFIG: begin
						buffer_addr  <= base_reg;
						order_select <= lifo_reg;
						col_reg      <= '0;
						row_reg      <= '0;
						astate_reg   <= stream_reg ? AG_STREAM : AG_CONTIG;
					end
					AG_STREAM, AG_CONTIG: begin
						if (ack_ok) begin
							if (astate_reg == AG_STREAM) begin
								buffer_addr <= buffer_addr + sstep;
							end else if (last_col) begin
								buffer_addr <= buffer_addr + rstep_reg;
							end else begin
								buffer_addr <= buffer_addr + cstep_reg;
							end
							if (last_col) begin
								col_reg <= '0;
								if (last_row) begin
									row_reg    <= '0;
									frame_done <= 1'b1;
									astate_reg <= AG_IDLE;
								end else begin
									row_reg <= row_reg + 16'h0001;
								end
							end else begin
								col_reg <= col_reg + 16'h0001;
							end
						end
					end
					default: begin
						astate_reg <= AG_IDLE;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// Burst status and read request
	// ************************************************************
	// A long acknowledge counts once per rising edge, matching separate strobes.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bstate_reg         <= BS_IDLE;
			acnt_reg           <= 2'h0;
			burst_read_request <= 1'b0;
		end else if (srst) begin
			bstate_reg         <= BS_IDLE;
			acnt_reg           <= 2'h0;
			burst_read_request <= 1'b0;
		end else if (rise_en) begin
			case (bstate_reg)
				BS_IDLE: begin
					acnt_reg <= 2'h0;
					if (filled_reg) begin
						burst_read_request <= 1'b1;
						bstate_reg         <= BS_PEND;
					end
				end
				BS_PEND: begin
					if (ack_ok) begin
						if (acnt_reg == WCNT_LAST) begin
							burst_read_request <= 1'b0;
							bstate_reg         <= BS_IDLE;
						end else begin
							acnt_reg <= acnt_reg + 2'h1;
						end
					end
				end
				default: begin
					bstate_reg <= BS_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Ping-pong burst buffer
	// ************************************************************
	pbf_burst_buf #(
		.BURST (BURST),
		.DEPTH (BANK_DEPTH),
		.W     (PIX_W)
	) u_buf (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.srst       (srst),
		.rise_en    (rise_en),
		.fall_en    (fall_en),
		.wr_strobe  (converted_word_strobe),
		.wr_data    (conv_data),
		.rd_strobe  (ack_ok),
		.order_lifo (order_select),
		.rd_data    (pixel_data),
		.bank_full  ()
	);

endmodule : pbf_acq_top

/* File: tb/pbf_acq_sva.sv */
/*
 * Checker for the acquisition block handshake and output timing.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module pbf_acq_sva (
	input wire logic                          clk_sys,
	input wire logic                          rstn,
	input wire logic                          inverted_transfer_clock,
	input wire logic                          read_ack_strobe,
	input wire logic                          burst_read_request,
	input wire logic [pbf_pkg::PIX_W-1:0]     pixel_data,
	input wire logic [pbf_pkg::ADDR_W-1:0]    buffer_addr,
	input wire logic                          order_select,
	input wire logic                          reg_wr
);
	logic       itc_d;
	logic       re_d;
	logic       wr_d;
	logic [2:0] acc_cnt;
	wire        re  = inverted_transfer_clock && !itc_d;
	wire        acc = re && burst_read_request && read_ack_strobe;
	// A soft reset write may drop the request, so the drop, length and output edge checks skip the cycle after any register write.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			itc_d   <= 1'b0;
			re_d    <= 1'b0;
			wr_d    <= 1'b0;
			acc_cnt <= 3'h0;
		end else begin
			itc_d   <= inverted_transfer_clock;
			re_d    <= re;
			wr_d    <= reg_wr;
			acc_cnt <= !burst_read_request ? 3'h0 : acc_cnt + 3'(acc);
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	rise_edge_a: assert property ($rose(burst_read_request) |-> re_d)
		else $error("request rose off a rising edge");
	fall_cnt_a: assert property ($fell(burst_read_request) && !wr_d |-> acc_cnt == 3'h4)
		else $error("request dropped before four acks");
	drop_now_a: assert property (acc_cnt == 3'h4 |-> !burst_read_request)
		else $error("request held after four acks");
	hold_req_a: assert property (burst_read_request && !acc && !reg_wr |=> burst_read_request)
		else $error("request dropped without ack");
	addr_edge_a: assert property ($changed(buffer_addr) && !wr_d |-> re_d)
		else $error("address moved off a rising edge");
	pix_edge_a: assert property ($changed(pixel_data) && !wr_d |-> re_d)
		else $error("pixel data moved off a rising edge");
	order_edge_a: assert property ($changed(order_select) && !wr_d |-> re_d)
		else $error("order select moved off a rising edge");
	min_len_a: assert property (disable iff (!rstn || wr_d)
		$rose(burst_read_request) |-> burst_read_request[*8])
		else $error("request shorter than two transfer cycles");
	cover property ($rose(burst_read_request));
	cover property (acc_cnt == 3'h4);
	cover property ($rose(order_select));
endmodule : pbf_acq_sva

/* File: tb/pbf_sel_model.sv */
/*
 * Behavioural pixel data selector answering burst read requests.
 * Assumes transfer clock level and request are synchronous to clk_sys.
 */
`timescale 1ns/1ps
module pbf_sel_model (
	input  wire logic clk_sys,
	input  wire logic itc,
	input  wire logic req,
	input  wire logic level,
	input  wire logic slow,
	input  wire logic rogue,
	output logic      ack,
	output logic      take
);
	logic p     = 1'b0;
	logic ack_r = 1'b0;
	logic skip  = 1'b0;
	initial take = 1'b0;
	// Acks launch after a falling edge so they are settled at the next rising edge.
	assign ack = ack_r | rogue;
	always @(posedge clk_sys) begin
		p    <= itc;
		take <= 1'b0;
		if (!itc && p) begin
			skip <= ~skip;
			if (req && !(slow && skip)) begin
				ack_r <= 1'b1;
				take  <= 1'b1;
			end
		end else if ((itc && !p && !level) || !req) begin
			ack_r <= 1'b0;
		end
	end
endmodule : pbf_sel_model

/* File: tb/pbf_acq_top_tb.sv */
/*
 * Self-checking bench for the acquisition block with a selector model.
 * Assumes the register map and timing of the design package.
 */
`timescale 1ns/1ps
module pbf_acq_top_tb;
	import pbf_pkg::*;
	logic              clk_sys = 1'b0, rstn = 1'b0, xb = 1'b0, ws = 1'b0, wr = 1'b0, rd = 1'b0;
	logic              md = 1'b0, sl = 1'b0, rg = 1'b0, ack, req, osel, take, itc;
	logic [PIX_W-1:0]  cd = '0, pix;
	logic [ADDR_W-1:0] ba;
	logic [REG_AW-1:0] ra = '0;
	logic [31:0]       wd = '0, rdat;
	logic [1:0]        tc = 2'h0;
	logic [PIX_W-1:0]  gp[$];
	logic [ADDR_W-1:0] ga[$];
	int                err_count = 0, check_count = 0, cyc = 0;
	assign itc = tc[1];
	always #25 clk_sys = ~clk_sys;
	pbf_acq_top dut (.clk_sys(clk_sys), .rstn(rstn), .inverted_transfer_clock(itc),
		.exposure_begin_pulse(xb), .converted_word_strobe(ws), .conv_data(cd), .read_ack_strobe(ack),
		.burst_read_request(req), .pixel_data(pix), .buffer_addr(ba), .order_select(osel),
		.reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat));
	pbf_sel_model sel (.clk_sys(clk_sys), .itc(itc), .req(req), .level(md), .slow(sl), .rogue(rg),
		.ack(ack), .take(take));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	always @(posedge clk_sys) begin
		tc  <= tc + 2'h1;
		cyc <= cyc + 1;
		if (take) begin
			gp.push_back(pix);
			ga.push_back(ba);
		end
		if (cyc == 6000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		ra <= a;
		wd <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		rd <= 1'b1;
		ra <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		@(posedge clk_sys);
		chk(rdat, e);
	endtask : rreg
	// Two bursts of four words make one frame of two rows; a rogue ack may come before the words.
	task automatic frame(input logic s, l, r, input logic [24:0] b, cs, rs, input logic [3:0] n);
		logic [24:0] e;
		int          k;
		wreg(OFS_CTRL, 32'({n, 1'b0, l, s}));
		wreg(OFS_BASE, 32'(b));
		wreg(OFS_CSTEP, 32'(cs));
		wreg(OFS_RSTEP, 32'(rs));
		wreg(OFS_NCOL, 32'h4);
		wreg(OFS_NROW, 32'h2);
		@(posedge clk_sys);
		xb <= 1'b1;
		@(posedge clk_sys);
		xb <= 1'b0;
		repeat (12) @(posedge clk_sys);
		rg <= r;
		repeat (8) @(posedge clk_sys);
		rg <= 1'b0;
		chk(32'(osel), 32'(l));
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 4; i++) begin
				do @(posedge clk_sys); while (tc != 2'h3);
				ws <= 1'b1;
				cd <= 18'h2a000 + 18'(j * 4 + i);
				@(posedge clk_sys);
				ws <= 1'b0;
			end
			k = 0;
			while ((gp.size() < 4 * (j + 1) || req) && k < 400) begin
				@(posedge clk_sys);
				k++;
			end
		end
		e = b;
		for (k = 0; k < 8; k++) begin
			chk(32'(gp[k]), 32'(18'h2a000 + 18'(k - k % 4 + (l ? 3 - k % 4 : k % 4))));
			chk(32'(ga[k]), 32'(e));
			e = e + (s ? (l ? -25'(n) : 25'(n)) : (k % 4 == 3 ? rs : cs));
		end
		rreg(OFS_STATUS, 32'h0);
		gp.delete();
		ga.delete();
	endtask : frame
	task automatic t_reset;
		rreg(OFS_CTRL, 32'h9);
		rreg(OFS_CSTEP, 32'h1);
		rreg(OFS_NCOL, 32'h4);
		rreg(OFS_STATUS, 32'h0);
		rreg(8'h20, 32'h0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_stream;
		frame(1'b1, 1'b0, 1'b0, 25'h10, 25'h1, 25'h4, 4'h2);
		$display("stream test done");
	endtask : t_stream
	task automatic t_contig;
		md <= 1'b1;
		frame(1'b0, 1'b1, 1'b0, 25'h100, 25'h1ffffff, 25'h1fffffc, 4'h1);
		md <= 1'b0;
		$display("contiguous test done");
	endtask : t_contig
	// A soft reset lands while a burst is being drained; the next frame must start clean.
	task automatic t_srst;
		wreg(OFS_CTRL, 32'h9);
		@(posedge clk_sys);
		xb <= 1'b1;
		@(posedge clk_sys);
		xb <= 1'b0;
		repeat (20) @(posedge clk_sys);
		for (int i = 0; i < 4; i++) begin
			do @(posedge clk_sys); while (tc != 2'h3);
			ws <= 1'b1;
			@(posedge clk_sys);
			ws <= 1'b0;
		end
		@(posedge clk_sys);
		rreg(OFS_STATUS, 32'hf);
		rreg(OFS_STATUS, 32'hd);
		wreg(OFS_CTRL, 32'hd);
		rreg(OFS_STATUS, 32'h0);
		rreg(OFS_CTRL, 32'h9);
		gp.delete();
		ga.delete();
		$display("soft reset test done");
	endtask : t_srst
	task automatic t_slow;
		sl <= 1'b1;
		frame(1'b1, 1'b1, 1'b1, 25'h40, 25'h1, 25'h4, 4'h4);
		sl <= 1'b0;
		$display("slow ack test done");
	endtask : t_slow
	initial begin
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset();
		t_stream();
		t_contig();
		t_srst();
		t_slow();
		end_sim();
	end
endmodule : pbf_acq_top_tb
bind pbf_acq_top pbf_acq_sva sva_i (.clk_sys(clk_sys), .rstn(rstn),
	.inverted_transfer_clock(inverted_transfer_clock), .read_ack_strobe(read_ack_strobe),
	.burst_read_request(burst_read_request), .pixel_data(pixel_data), .buffer_addr(buffer_addr),
	.order_select(order_select), .reg_wr(reg_wr));
